// file: inc/cfg_port_pkg.sv
package cfg_port_pkg;
  localparam int          ADDR_W    = 5;
  localparam int          BYTE_W    = 8;
  localparam int          CNT_W     = 3;
  localparam logic [2:0]  LAST_BIT  = 3'h7;
  localparam logic [2:0]  FIRST_BIT = 3'h0;
  localparam logic [4:0]  ADDR_MIN  = 5'h00;
  localparam logic [4:0]  ADDR_MAX  = 5'h1f;
  localparam logic [4:0]  CTRL_ADDR = 5'h00;
  localparam logic [7:0]  REG_RESET = 8'h00;
  localparam logic        LBF_RESET = 1'b0;
  localparam int          LBF_BIT   = 6;
  localparam int          RW_BIT    = 7;
  localparam int          CNT_HI    = 6;
  localparam int          CNT_LO    = 5;
  localparam int          SYNC_W    = 4;
  localparam int          SY_SCLK   = 0;
  localparam int          SY_SEL    = 1;
  localparam int          SY_SDIO   = 2;
  localparam int          SY_RM     = 3;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_INSTR = 2'b01,
    ST_DATA  = 2'b10,
    ST_DONE  = 2'b11
  } port_state_e;
endpackage

// file: inc/reg_mem_if.sv
`timescale 1ns/1ps
interface reg_mem_if #(
  parameter int ADDR_W = cfg_port_pkg::ADDR_W,
  parameter int DATA_W = cfg_port_pkg::BYTE_W
);
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [ADDR_W-1:0] a_addr;
  logic [DATA_W-1:0] a_data;
  logic [ADDR_W-1:0] b_addr;
  logic [DATA_W-1:0] b_data;

  modport ctrl (output wr_en, wr_addr, wr_data, a_addr, b_addr, input a_data, b_data);
  modport mem  (input wr_en, wr_addr, wr_data, a_addr, b_addr, output a_data, b_data);
endinterface

// file: rtl/cfg_reg_mem.sv
`timescale 1ns/1ps
module cfg_reg_mem #(
  parameter int ADDR_W = cfg_port_pkg::ADDR_W,
  parameter int DATA_W = cfg_port_pkg::BYTE_W
) (
  input  wire logic clock_in,  // Core clock
  input  wire logic rst_n_in,  // Synchronised reset, active low
  reg_mem_if.mem    bus        // Write port and two registered read ports
);
  localparam int DEPTH = 1 << ADDR_W;

  if (ADDR_W < 1 || DATA_W < 1) begin : g_chk
    $error("cfg_reg_mem: widths must be positive");
  end

  logic [DATA_W-1:0] store [DEPTH];

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        store[i] <= DATA_W'(cfg_port_pkg::REG_RESET);
      end
    end else if (bus.wr_en) begin
      store[bus.wr_addr] <= bus.wr_data;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bus.a_data <= '0;
      bus.b_data <= '0;
    end else begin
      bus.a_data <= store[bus.a_addr];
      bus.b_data <= store[bus.b_addr];
    end
  end
endmodule

// file: rtl/dual_dac_serial_config_port.sv
// Behaviour
// - A cycle starts with an instruction byte taken on the first eight serial clock rises, then data follows.
// - A high then low on the port reset/mode pin returns the port to the start of the instruction phase.
// - A port reset or select loss mid-cycle discards the partial byte and writes nothing.
// - Instruction bits 6 and 5 give one to four data bytes and exactly that many are moved.
// - Each written byte lands in its register as soon as its eighth bit is taken.
// - Instruction bit 7 high asks for a read, low for a write.
// - Instruction bits 4 to 0 give the first register address.
// - Later addresses of a multibyte cycle are stepped internally as the bit order selection says.
// - One two-way data pin carries instruction and data, received for writes and driven for reads.
// - Most-bit-first steps the address down toward 0x00, least-bit-first up toward 0x1F.
// - Incoming bits are taken on serial clock rises and read bits driven on falls.
// - The active-low select frames the cycle and the data pin is released while it is high.
// - Bit order resets to most significant first and bit 6 of register 0x00 set flips both bytes kinds.
`timescale 1ns/1ps
module dual_dac_serial_config_port (
  input  wire logic                             clock_in,               // Core clock, 125 MHz
  input  wire logic                             resetn_in,              // Async reset, active low
  input  wire logic                             sclk_in,                // Serial clock from controller
  input  wire logic                             select_n_in,            // Cycle select, active low
  input  wire logic                             sdio_in,                // Data pin level
  output logic                                  sdio_data_out,          // Data pin drive value
  output logic                                  sdio_oe_out,            // Data pin drive enable
  input  wire logic                             port_reset_mode_pin_in, // Port reset/mode pin
  input  wire logic [cfg_port_pkg::ADDR_W-1:0]  loc_addr_in,            // Local register address
  input  wire logic [cfg_port_pkg::BYTE_W-1:0]  loc_wdata_in,           // Local write data
  input  wire logic                             loc_wr_in,              // Local write strobe
  input  wire logic                             loc_rd_in,              // Local read strobe
  output logic      [cfg_port_pkg::BYTE_W-1:0]  loc_rdata_out,          // Local read data
  output logic                                  low_bit_first_out       // Current bit order
);
  localparam int AW = cfg_port_pkg::ADDR_W;
  localparam int BW = cfg_port_pkg::BYTE_W;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and input synchronisers
  logic                            rst_meta;
  logic                            rst_n;
  logic [cfg_port_pkg::SYNC_W-1:0] in_meta;
  logic [cfg_port_pkg::SYNC_W-1:0] in_sync;
  logic                            sclk_prev;
  logic                            rm_prev;

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      in_meta   <= 4'h2;
      in_sync   <= 4'h2;
      sclk_prev <= 1'b0;
      rm_prev   <= 1'b0;
    end else begin
      in_meta   <= {port_reset_mode_pin_in, sdio_in, select_n_in, sclk_in};
      in_sync   <= in_meta;
      sclk_prev <= in_sync[cfg_port_pkg::SY_SCLK];
      rm_prev   <= in_sync[cfg_port_pkg::SY_RM];
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic sel_off;
  logic rm_high;
  logic rm_fall;
  logic sdio_s;
  logic abort;

  assign sclk_rise = in_sync[cfg_port_pkg::SY_SCLK] & ~sclk_prev;
  assign sclk_fall = ~in_sync[cfg_port_pkg::SY_SCLK] & sclk_prev;
  assign sel_off   = in_sync[cfg_port_pkg::SY_SEL];
  assign rm_high   = in_sync[cfg_port_pkg::SY_RM];
  assign rm_fall   = rm_prev & ~rm_high;
  assign sdio_s    = in_sync[cfg_port_pkg::SY_SDIO];
  assign abort     = sel_off | rm_high;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [BW-1:0] shift_in(input logic [BW-1:0] sh, input logic b, input logic lbf);
    shift_in = lbf ? {b, sh[BW-1:1]} : {sh[BW-2:0], b};
  endfunction

  function automatic logic [AW-1:0] step_addr(input logic [AW-1:0] a, input logic lbf);
    if (lbf) begin
      step_addr = (a == cfg_port_pkg::ADDR_MAX) ? a : AW'(a + 1'b1);
    end else begin
      step_addr = (a == cfg_port_pkg::ADDR_MIN) ? a : AW'(a - 1'b1);
    end
  endfunction

  function automatic logic [2:0] bit_pos(input logic [2:0] cnt, input logic lbf);
    bit_pos = lbf ? cnt : 3'(cfg_port_pkg::LAST_BIT - cnt);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  reg_mem_if mem_bus ();

  cfg_reg_mem u_mem (
    .clock_in (clock_in),
    .rst_n_in (rst_n),
    .bus      (mem_bus)
  );

  cfg_port_pkg::port_state_e state;
  cfg_port_pkg::port_state_e next_state;
  logic [2:0]                bit_cnt;
  logic [BW-1:0]             rx_shift;
  logic [BW-1:0]             next_rx;
  logic [AW-1:0]             addr;
  logic [1:0]                bytes_left;
  logic                      rd_dir;
  logic                      lbf;
  logic                      next_lbf;
  logic                      byte_done;
  logic                      ser_wr;
  logic                      loc_wr_ok;

  assign next_rx   = shift_in(rx_shift, sdio_s, lbf);
  assign byte_done = sclk_rise && (bit_cnt == cfg_port_pkg::LAST_BIT) && !abort;
  assign ser_wr    = (state == cfg_port_pkg::ST_DATA) && !rd_dir && byte_done;
  assign loc_wr_ok = loc_wr_in && !ser_wr;

  always_comb begin
    next_lbf = lbf;
    if (ser_wr && addr == cfg_port_pkg::CTRL_ADDR) begin
      next_lbf = next_rx[cfg_port_pkg::LBF_BIT];
    end else if (loc_wr_ok && loc_addr_in == cfg_port_pkg::CTRL_ADDR) begin
      next_lbf = loc_wdata_in[cfg_port_pkg::LBF_BIT];
    end
  end

  always_comb begin
    next_state = state;
    if (abort) begin
      next_state = cfg_port_pkg::ST_IDLE;
    end else begin
      unique case (state)
        cfg_port_pkg::ST_IDLE: begin
          next_state = cfg_port_pkg::ST_INSTR;
        end
        cfg_port_pkg::ST_INSTR: begin
          if (byte_done) begin
            next_state = cfg_port_pkg::ST_DATA;
          end
        end
        cfg_port_pkg::ST_DATA: begin
          if (byte_done && bytes_left == 2'h0) begin
            next_state = cfg_port_pkg::ST_DONE;
          end
        end
        cfg_port_pkg::ST_DONE: begin
          next_state = cfg_port_pkg::ST_DONE;
        end
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      state <= cfg_port_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Bit counter and receive shifter; partial bytes are dropped on abort
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt  <= cfg_port_pkg::FIRST_BIT;
      rx_shift <= '0;
    end else if (abort || state == cfg_port_pkg::ST_IDLE) begin
      bit_cnt  <= cfg_port_pkg::FIRST_BIT;
      rx_shift <= '0;
    end else if (sclk_rise) begin
      bit_cnt  <= 3'(bit_cnt + 1'b1);
      rx_shift <= next_rx;
    end
  end

  // Instruction decode and address generation
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      rd_dir     <= 1'b0;
      bytes_left <= 2'h0;
      addr       <= cfg_port_pkg::ADDR_MIN;
    end else if (state == cfg_port_pkg::ST_INSTR && byte_done) begin
      rd_dir     <= next_rx[cfg_port_pkg::RW_BIT];
      bytes_left <= {next_rx[cfg_port_pkg::CNT_HI], next_rx[cfg_port_pkg::CNT_LO]};
      addr       <= next_rx[AW-1:0];
    end else if (state == cfg_port_pkg::ST_DATA && byte_done) begin
      bytes_left <= 2'(bytes_left - 1'b1);
      addr       <= step_addr(addr, next_lbf);
    end
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      lbf <= cfg_port_pkg::LBF_RESET;
    end else begin
      lbf <= next_lbf;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data pin drive
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      sdio_oe_out <= 1'b0;
    end else if (abort) begin
      sdio_oe_out <= 1'b0;
    end else if (state == cfg_port_pkg::ST_INSTR && byte_done) begin
      sdio_oe_out <= next_rx[cfg_port_pkg::RW_BIT];
    end else if (state == cfg_port_pkg::ST_DATA && byte_done && bytes_left == 2'h0) begin
      sdio_oe_out <= 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      sdio_data_out <= 1'b0;
    end else if (sclk_fall && state == cfg_port_pkg::ST_DATA && rd_dir) begin
      sdio_data_out <= mem_bus.a_data[bit_pos(bit_cnt, lbf)];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register store access
  assign mem_bus.wr_en   = ser_wr | loc_wr_ok;
  assign mem_bus.wr_addr = ser_wr ? addr : loc_addr_in;
  assign mem_bus.wr_data = ser_wr ? next_rx : loc_wdata_in;
  assign mem_bus.a_addr  = addr;
  assign mem_bus.b_addr  = loc_addr_in;

  logic rd_seen;

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      rd_seen <= 1'b0;
    end else begin
      rd_seen <= loc_rd_in;
    end
  end

  assign loc_rdata_out     = rd_seen ? mem_bus.b_data : '0;
  assign low_bit_first_out = lbf;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_INSTR_TO_DATA: assert property (@(posedge clock_in) disable iff (!rst_n)
    state == cfg_port_pkg::ST_INSTR && byte_done |=> state == cfg_port_pkg::ST_DATA)
    else $error("instruction byte did not open the data phase");

  AST_PIN_RESTART: assert property (@(posedge clock_in) disable iff (!rst_n)
    rm_fall && !sel_off |=> state == cfg_port_pkg::ST_INSTR && bit_cnt == cfg_port_pkg::FIRST_BIT)
    else $error("port reset pin did not restart the instruction phase");

  AST_NO_WRITE_ON_ABORT: assert property (@(posedge clock_in) disable iff (!rst_n)
    abort |-> !ser_wr ##1 bit_cnt == cfg_port_pkg::FIRST_BIT)
    else $error("aborted cycle wrote or kept partial bits");

  AST_LAST_BYTE_ENDS: assert property (@(posedge clock_in) disable iff (!rst_n)
    state == cfg_port_pkg::ST_DATA && byte_done && bytes_left == 2'h0
      |=> state == cfg_port_pkg::ST_DONE && !sdio_oe_out)
    else $error("byte count not honoured");

  AST_ADDR_DOWN: assert property (@(posedge clock_in) disable iff (!rst_n)
    state == cfg_port_pkg::ST_DATA && byte_done && !next_lbf && addr != cfg_port_pkg::ADDR_MIN
      |=> addr == $past(addr) - 5'h01)
    else $error("address did not step down");

  AST_ADDR_UP: assert property (@(posedge clock_in) disable iff (!rst_n)
    state == cfg_port_pkg::ST_DATA && byte_done && next_lbf && addr != cfg_port_pkg::ADDR_MAX
      |=> addr == $past(addr) + 5'h01)
    else $error("address did not step up");

  AST_SAMPLE_ON_RISE: assert property (@(posedge clock_in) disable iff (!rst_n)
    !sclk_rise && !abort && state != cfg_port_pkg::ST_IDLE |=> $stable(rx_shift))
    else $error("receive shifter moved without a serial clock rise");

  AST_DRIVE_ON_FALL: assert property (@(posedge clock_in) disable iff (!rst_n)
    $changed(sdio_data_out) |-> $past(sclk_fall) && $past(rd_dir))
    else $error("read bit changed away from a falling edge");

  AST_RELEASE_ON_SELECT: assert property (@(posedge clock_in) disable iff (!rst_n)
    sel_off |=> !sdio_oe_out)
    else $error("data pin driven while not selected");

  AST_OE_ONLY_IN_READ: assert property (@(posedge clock_in) disable iff (!rst_n)
    sdio_oe_out |-> state == cfg_port_pkg::ST_DATA && rd_dir)
    else $error("data pin driven outside a read data phase");
endmodule

// file: tb/cfg_master_model.sv
`timescale 1ns/1ps
module cfg_master_model (
  input  wire logic clock_in,      // Core clock used as time base
  input  wire logic sdio_in,       // Resolved data line
  output logic      sclk_out,      // Serial clock, idle low
  output logic      select_n_out,  // Cycle select, active low
  output logic      sdio_out,      // Data driven by the controller
  output logic      sdio_en_out,   // Controller drives the data line
  output logic      reset_pin_out  // Port reset/mode pin
);
  initial begin
    sclk_out      <= 1'b0;
    select_n_out  <= 1'b1;
    sdio_out      <= 1'b0;
    sdio_en_out   <= 1'b0;
    reset_pin_out <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Half a serial clock period, 32 ns
  task automatic half();
    repeat (4) @(posedge clock_in);
  endtask

  task automatic frame_begin();
    select_n_out <= 1'b0;
    half();
  endtask

  task automatic frame_end();
    sclk_out    <= 1'b0;
    sdio_en_out <= 1'b0;
    half();
    select_n_out <= 1'b1;
    half();
  endtask

  // Data changes while the clock is low; read bits are taken at the rising edge
  task automatic shift(input logic [7:0] b, input logic lsb, input int n, input logic drive, output logic [7:0] got);
    got = 8'h00;
    for (int i = 0; i < n; i++) begin
      sclk_out    <= 1'b0;
      sdio_en_out <= drive;
      sdio_out    <= lsb ? b[i] : b[7-i];
      half();
      if (lsb) got[i] = sdio_in;
      else got[7-i] = sdio_in;
      sclk_out <= 1'b1;
      half();
    end
  endtask

  task automatic port_reset();
    sclk_out      <= 1'b0;
    sdio_en_out   <= 1'b0;
    reset_pin_out <= 1'b1;
    half();
    half();
    reset_pin_out <= 1'b0;
    half();
  endtask
endmodule

// file: tb/dual_dac_serial_config_port_tb_top.sv
`timescale 1ns/1ps
module dual_dac_serial_config_port_tb_top;
  logic       clock_in;
  logic       resetn_in;
  logic       sclk;
  logic       select_n;
  logic       sdio_m;
  logic       sdio_m_en;
  logic       rpin;
  logic       sdio_data;
  logic       sdio_oe;
  logic       sdio_line;
  logic [4:0] loc_addr;
  logic [7:0] loc_wdata;
  logic       loc_wr;
  logic       loc_rd;
  logic [7:0] loc_rdata;
  logic       lbf;
  logic [7:0] got;
  logic [7:0] rd [4];
  int         errors;
  int         comparisons;

  // Line has a pull-up when nobody drives it
  assign sdio_line = sdio_oe ? sdio_data : (sdio_m_en ? sdio_m : 1'b1);

  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end

  dual_dac_serial_config_port dut (
    .clock_in               (clock_in),
    .resetn_in              (resetn_in),
    .sclk_in                (sclk),
    .select_n_in            (select_n),
    .sdio_in                (sdio_line),
    .sdio_data_out          (sdio_data),
    .sdio_oe_out            (sdio_oe),
    .port_reset_mode_pin_in (rpin),
    .loc_addr_in            (loc_addr),
    .loc_wdata_in           (loc_wdata),
    .loc_wr_in              (loc_wr),
    .loc_rd_in              (loc_rd),
    .loc_rdata_out          (loc_rdata),
    .low_bit_first_out      (lbf)
  );

  cfg_master_model m (
    .clock_in      (clock_in),
    .sdio_in       (sdio_line),
    .sclk_out      (sclk),
    .select_n_out  (select_n),
    .sdio_out      (sdio_m),
    .sdio_en_out   (sdio_m_en),
    .reset_pin_out (rpin)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic lwrite(input logic [4:0] a, input logic [7:0] d);
    @(posedge clock_in);
    loc_wr    <= 1'b1;
    loc_addr  <= a;
    loc_wdata <= d;
    @(posedge clock_in);
    loc_wr <= 1'b0;
  endtask

  task automatic lchk(input logic [4:0] a, input logic [7:0] exp);
    @(posedge clock_in);
    loc_rd   <= 1'b1;
    loc_addr <= a;
    @(posedge clock_in);
    loc_rd <= 1'b0;
    @(posedge clock_in);
    chk(loc_rdata, exp);
  endtask

  task automatic sframe(input logic [7:0] ins, input logic [7:0] d [4], input int n, input logic lsb);
    m.frame_begin();
    m.shift(ins, lsb, 8, 1'b1, got);
    for (int k = 0; k < n; k++) m.shift(d[k], lsb, 8, !ins[7], rd[k]);
    m.frame_end();
  endtask

  task automatic final_report();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (40000) @(posedge clock_in);
    errors++;
    final_report();
  end

  initial begin
    errors      = 0;
    comparisons = 0;
    resetn_in   = 1'b0;
    loc_addr    = 5'h00;
    loc_wdata   = 8'h00;
    loc_wr      = 1'b0;
    loc_rd      = 1'b0;
    repeat (4) @(posedge clock_in);
    resetn_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    lchk(5'h03, 8'h00);
    chk({7'h00, lbf}, 8'h00);
    $display("test reset_state done");
    sframe(8'h03, '{8'ha5, 8'h00, 8'h00, 8'h00}, 1, 1'b0);
    lchk(5'h03, 8'ha5);
    $display("test single_write done");
    sframe(8'h67, '{8'h11, 8'h22, 8'h33, 8'h44}, 4, 1'b0);
    lchk(5'h07, 8'h11);
    lchk(5'h06, 8'h22);
    lchk(5'h04, 8'h44);
    $display("test multi_write done");
    sframe(8'ha7, '{8'h00, 8'h00, 8'h00, 8'h00}, 2, 1'b0);
    chk(rd[0], 8'h11);
    chk(rd[1], 8'h22);
    chk({7'h00, sdio_oe}, 8'h00);
    m.frame_begin();
    m.shift(8'hc7, 1'b0, 8, 1'b1, got);
    chk({7'h00, sdio_oe}, 8'h01);
    for (int k = 0; k < 3; k++) m.shift(8'h00, 1'b0, 8, 1'b0, rd[k]);
    m.frame_end();
    chk(rd[2], 8'h33);
    $display("test multi_read done");
    // One byte asked, one extra byte clocked before select rises
    m.frame_begin();
    m.shift(8'h08, 1'b0, 8, 1'b1, got);
    m.shift(8'h5a, 1'b0, 8, 1'b1, got);
    lchk(5'h08, 8'h5a);
    m.shift(8'hff, 1'b0, 8, 1'b1, got);
    m.frame_end();
    lchk(5'h07, 8'h11);
    $display("test byte_count done");
    m.frame_begin();
    m.shift(8'h02, 1'b0, 8, 1'b1, got);
    m.shift(8'hff, 1'b0, 4, 1'b1, got);
    m.port_reset();
    m.shift(8'h09, 1'b0, 8, 1'b1, got);
    m.shift(8'h77, 1'b0, 8, 1'b1, got);
    m.frame_end();
    lchk(5'h02, 8'h00);
    lchk(5'h09, 8'h77);
    $display("test port_reset done");
    m.frame_begin();
    m.shift(8'h0c, 1'b0, 8, 1'b1, got);
    m.shift(8'hff, 1'b0, 5, 1'b1, got);
    m.frame_end();
    lchk(5'h0c, 8'h00);
    $display("test select_loss done");
    sframe(8'h00, '{8'h40, 8'h00, 8'h00, 8'h00}, 1, 1'b0);
    chk({7'h00, lbf}, 8'h01);
    sframe(8'h2a, '{8'h3c, 8'hc3, 8'h00, 8'h00}, 2, 1'b1);
    lchk(5'h0b, 8'hc3);
    sframe(8'haa, '{8'h00, 8'h00, 8'h00, 8'h00}, 2, 1'b1);
    chk(rd[0], 8'h3c);
    chk(rd[1], 8'hc3);
    lwrite(5'h00, 8'h00);
    @(posedge clock_in);
    chk({7'h00, lbf}, 8'h00);
    $display("test low_bit_first done");
    final_report();
  end
endmodule
